// [hdl/half_bridge_fault_control.sv]
/*
 * Control and protection logic of a serially commanded twelve-channel half-bridge
 * driver: serial frame port, output enables, fault flags, shutdowns.
 * Assumes all status pins and the serial port are asynchronous to
 * clk_in and that the serial clock is far slower than clk_in.
 */
// Overview of operation
// - Sleep clears every programmed bit; host rewrites after waking.
// - All outputs start off after power-up until commanded on.
// - Logic supply power-up resets control logic, drivers disabled.
// - Frames are accepted only while logic supply is above lockout.
// - Output stays on until undervoltage, command off or fault.
// - Driver supply changes never clear programmed state.
// - Overcurrent policy 1: offending output latches off until reset.
// - Any overcurrent sets overload flag, held until status reset.
// - No output turns on while over thermal shutdown level.
// - Enabled output underloaded past delay sets underload flag.
// - Underload policy 1 latches offending output off until reset.
// - Overvoltage on either driver supply sets supply-fail flag.
// - Overvoltage policy 1 turns outputs off, resumes on recovery.
// - Overvoltage policy 0 only sets the flag.
// - Thermal warning sets warning flag, outputs stay on.
// - Any of six sensors over temperature switches all off.
// - Thermal shutdown keeps programmed selection, resumes on cooling.
// - Warning flag stays latched until a status reset frame.
// - Chip select falling presents warning flag on serial out.
// - 16-bit frame, LSB first, committed on chip select rise.
// - Output frame: flags 15..13, outputs 12..1, warning 0.
`include "hb_fault_map.svh"

module half_bridge_fault_control (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic awake_in,
    input wire logic logic_supply_ok_in,
    input wire logic driver_supply_uv_in,
    input wire logic driver_supply_a_ov_in,
    input wire logic driver_supply_b_ov_in,
    input wire logic [`CHANNELS-1:0] overcurrent_in,
    input wire logic [`CHANNELS-1:0] underload_in,
    input wire logic [`SENSORS-1:0] thermal_warn_in,
    input wire logic [`SENSORS-1:0] over_temp_in,
    input wire logic chip_select_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic [`CHANNELS-1:0] output_driver_n_out
);

    // =================================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // =================================================================
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    hb_fault_pkg::pins_t pins_raw, s1_q, s2_q, s3_q, pin_q;

    assign pins_raw = {driver_supply_a_ov_in, driver_supply_b_ov_in,
        driver_supply_uv_in, logic_supply_ok_in, awake_in,
        overcurrent_in, underload_in, thermal_warn_in, over_temp_in,
        chip_select_n_in, sclk_in, sdi_in};

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= hb_fault_pkg::pins_t'(`PINS_RST);
            s2_q <= hb_fault_pkg::pins_t'(`PINS_RST);
            s3_q <= hb_fault_pkg::pins_t'(`PINS_RST);
            pin_q <= hb_fault_pkg::pins_t'(`PINS_RST);
        end else if (clk_en_in) begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= hb_fault_pkg::pins_t'((s2_q & s3_q)
                | (pin_q & (s2_q | s3_q)));
        end
    end

    // =================================================================
    // Derived conditions
    logic soft_clr, ov_now, ot_any, cs_fall, cs_rise, sclk_rise, sclk_fall;
    logic sclk_prev_q, cs_prev_q;

    // Sleep or logic supply loss wipes selection, flags, latch-offs, timers and outputs
    assign soft_clr = !pin_q.awake || !pin_q.logic_supply_ok;
    assign ov_now = pin_q.supply_a_ov || pin_q.supply_b_ov;
    assign ot_any = |pin_q.over_temp;
    assign cs_fall = cs_prev_q && !pin_q.chip_select_n;
    assign cs_rise = !cs_prev_q && pin_q.chip_select_n;
    assign sclk_rise = !sclk_prev_q && pin_q.sclk;
    assign sclk_fall = sclk_prev_q && !pin_q.sclk;

    // Edge history of the filtered serial pins
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'h0;
            cs_prev_q <= 1'h1;
        end else if (clk_en_in) begin
            sclk_prev_q <= pin_q.sclk;
            cs_prev_q <= pin_q.chip_select_n;
        end
    end

    // =================================================================
    // Serial frame port
    hb_fault_pkg::frame_state_t state_q;
    logic [`FRAME_BITS-1:0] in_sr_q, out_sr_q;
    logic [4:0] bit_cnt_q;
    logic commit;
    hb_fault_pkg::stat_t status;

    // Frame counts only when exactly 16 bits came in
    assign commit = (state_q == hb_fault_pkg::ST_FRAME) && cs_rise
        && (bit_cnt_q == 5'(`FRAME_BITS)) && !soft_clr;

    // Frame state
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= hb_fault_pkg::ST_IDLE;
        end else if (clk_en_in) begin
            case (state_q)
                hb_fault_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state_q <= hb_fault_pkg::ST_FRAME;
                    end
                end
                hb_fault_pkg::ST_FRAME: begin
                    if (cs_rise) begin
                        state_q <= hb_fault_pkg::ST_IDLE;
                    end
                end
                default: state_q <= hb_fault_pkg::ST_IDLE;
            endcase
        end
    end

    // Input shifter: sampled on rising serial clock, LSB first
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            in_sr_q <= `CTRL_RST;
            bit_cnt_q <= `BITCNT_RST;
        end else if (clk_en_in) begin
            if (cs_fall) begin
                bit_cnt_q <= `BITCNT_RST;
            end else if (state_q == hb_fault_pkg::ST_FRAME && sclk_rise) begin
                in_sr_q <= {pin_q.sdi, in_sr_q[`FRAME_BITS-1:1]};
                if (bit_cnt_q != 5'h1F) begin
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
            end
        end
    end

    // Output shifter: loaded at select, advanced on falling serial clock
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            out_sr_q <= `CTRL_RST;
            sdo_out <= 1'h0;
            sdo_oe_out <= 1'h0;
        end else if (clk_en_in) begin
            sdo_oe_out <= !pin_q.chip_select_n;
            if (cs_fall) begin
                out_sr_q <= status;
                sdo_out <= status.thermal_warning_flag;
            end else if (state_q == hb_fault_pkg::ST_FRAME && sclk_fall) begin
                out_sr_q <= {1'h0, out_sr_q[`FRAME_BITS-1:1]};
                sdo_out <= out_sr_q[1];
            end
        end
    end

    // =================================================================
    // Control register and fault flags
    hb_fault_pkg::ctrl_t ctrl_q;
    logic psf_q, ul_flag_q, ol_flag_q, warn_q;
    logic [`CHANNELS-1:0] latch_off_q, ul_event, oc_hit;
    logic flag_clr;

    assign flag_clr = commit && in_sr_q[`BIT_STATUS_RESET];
    assign oc_hit = pin_q.overcurrent & output_driver_n_out;

    // Committed frame; driver supply changes never touch it
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= hb_fault_pkg::ctrl_t'(`CTRL_RST);
        end else if (clk_en_in) begin
            if (soft_clr) begin
                ctrl_q <= hb_fault_pkg::ctrl_t'(`CTRL_RST);
            end else if (commit) begin
                ctrl_q <= hb_fault_pkg::ctrl_t'(in_sr_q);
            end
        end
    end

    // Sticky flags: a new event wins over a status reset
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            psf_q <= 1'h0;
            ul_flag_q <= 1'h0;
            ol_flag_q <= 1'h0;
            warn_q <= 1'h0;
        end else if (clk_en_in) begin
            if (soft_clr) begin
                psf_q <= 1'h0;
                ul_flag_q <= 1'h0;
                ol_flag_q <= 1'h0;
                warn_q <= 1'h0;
            end else begin
                psf_q <= (psf_q && !flag_clr) || ov_now
                    || pin_q.driver_uv;
                ul_flag_q <= (ul_flag_q && !flag_clr) || |ul_event;
                ol_flag_q <= (ol_flag_q && !flag_clr)
                    || |pin_q.overcurrent;
                warn_q <= (warn_q && !flag_clr) || |pin_q.warn;
            end
        end
    end

    // Latch-off per channel, released by status reset
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            latch_off_q <= '0;
        end else if (clk_en_in) begin
            if (soft_clr) begin
                latch_off_q <= '0;
            end else begin
                latch_off_q <= (latch_off_q & {`CHANNELS{!flag_clr}})
                    | (oc_hit & {`CHANNELS{ctrl_q.oc_policy}})
                    | (ul_event & {`CHANNELS{ctrl_q.ul_policy}});
            end
        end
    end

    // =================================================================
    // Underload delay timers, one per channel
    for (genvar i = 0; i < `CHANNELS; i++) begin : g_ul
        logic [11:0] ul_cnt_q;
        logic run;

        assign run = output_driver_n_out[i] && pin_q.underload[i];
        assign ul_event[i] = run && (ul_cnt_q == 12'(`UL_DELAY_CYC));

        always_ff @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
                ul_cnt_q <= 12'h000;
            end else if (clk_en_in) begin
                if (!run || soft_clr) begin
                    ul_cnt_q <= 12'h000;
                end else if (ul_cnt_q != 12'(`UL_DELAY_CYC)) begin
                    ul_cnt_q <= ul_cnt_q + 12'h001;
                end
            end
        end
    end

    // =================================================================
    // Output drivers: enables gated by shutdowns, selection untouched
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            output_driver_n_out <= '0;
        end else if (clk_en_in) begin
            if (soft_clr || ot_any || pin_q.driver_uv
                || (ov_now && ctrl_q.ov_policy)) begin
                output_driver_n_out <= '0;
            end else begin
                output_driver_n_out <= ctrl_q.enables & ~latch_off_q;
            end
        end
    end

    assign status = {psf_q, ul_flag_q, ol_flag_q, output_driver_n_out,
        warn_q};

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence seq_cs_fall;
        clk_en_in && cs_fall;
    endsequence

    sequence seq_commit;
        clk_en_in && commit && !soft_clr;
    endsequence

    a_clear_outputs: assert property (clk_en_in && soft_clr |=>
        output_driver_n_out == '0 && ctrl_q == '0)
        else $error("sleep or supply loss left state");
    a_thermal_off: assert property (clk_en_in && ot_any |=>
        output_driver_n_out == '0)
        else $error("output on during over temperature");
    a_ov_gate: assert property (clk_en_in && ov_now && ctrl_q.ov_policy
        |=> output_driver_n_out == '0)
        else $error("output on during overvoltage lockout");
    a_overload_set: assert property (clk_en_in && |pin_q.overcurrent
        && !soft_clr |=> ol_flag_q)
        else $error("overcurrent did not set overload flag");
    a_latch_hold: assert property (clk_en_in && !soft_clr && !flag_clr
        |=> (latch_off_q & $past(latch_off_q)) == $past(latch_off_q))
        else $error("latched-off output released without reset");
    a_warn_sticky: assert property (clk_en_in && warn_q && !soft_clr
        && !flag_clr |=> warn_q)
        else $error("warning flag dropped without reset");
    a_early_warn: assert property (seq_cs_fall |=>
        sdo_out == $past(warn_q) && !$past(pin_q.chip_select_n))
        else $error("warning not shown at select");
    a_frame_commit: assert property (seq_commit |=>
        ctrl_q == $past(in_sr_q))
        else $error("frame not committed at select rise");
    a_keep_select: assert property (clk_en_in && (ot_any || ov_now)
        && !commit && !soft_clr |=> $stable(ctrl_q))
        else $error("shutdown altered programmed selection");
    a_ul_latch: assert property (clk_en_in && |ul_event
        && ctrl_q.ul_policy && !soft_clr |=> ##1 |(latch_off_q
        & $past(ul_event, 2)) == (|$past(ul_event, 2)))
        else $error("underload did not latch output off");
    a_supply_fail: assert property (clk_en_in && ov_now && !soft_clr
        |=> psf_q)
        else $error("overvoltage did not set supply-fail flag");
    a_warn_set: assert property (clk_en_in && |pin_q.warn
        && !soft_clr |=> warn_q)
        else $error("thermal warning did not set warning flag");
    a_sdo_float: assert property (clk_en_in && pin_q.chip_select_n
        |=> !sdo_oe_out)
        else $error("serial out driven while deselected");
    a_ov_ignored: assert property (clk_en_in && ov_now
        && !ctrl_q.ov_policy && !ot_any && !soft_clr && !pin_q.driver_uv
        |=> output_driver_n_out == $past(ctrl_q.enables & ~latch_off_q))
        else $error("overvoltage changed outputs with policy off");

endmodule // half_bridge_fault_control

// [hdl/hb_fault_map.svh]
/*
 * Bit positions, reset values and timing counts of the half-bridge
 * fault control block.
 * Assumes a 40 MHz core clock; included by bare name from hdl/.
 */
`ifndef HB_FAULT_MAP_SVH
`define HB_FAULT_MAP_SVH

// =====================================================================
// Frame layout
`define FRAME_BITS 16
`define BIT_OV_POLICY 15
`define BIT_UL_POLICY 14
`define BIT_OC_POLICY 13
`define BIT_STATUS_RESET 0
`define CHANNELS 12
`define SENSORS 6

// =====================================================================
// Reset values
`define CTRL_RST 16'h0000
`define PINS_RST 44'h00000000004
`define BITCNT_RST 5'h00

// =====================================================================
// Timing
`define CLK_PERIOD_NS 25
`define UL_DELAY_NS 100000
`define UL_DELAY_CYC \
    ((`UL_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hdl/hb_fault_pkg.sv]
/*
 * Types of the half-bridge fault control block.
 * Assumes hb_fault_map.svh is on the include path.
 */
`include "hb_fault_map.svh"

package hb_fault_pkg;

    // =================================================================
    // Programming frame as committed
    typedef struct packed {
        logic ov_policy;
        logic ul_policy;
        logic oc_policy;
        logic [`CHANNELS-1:0] enables;
        logic status_reset_bit;
    } ctrl_t;

    // Status frame as shifted out
    typedef struct packed {
        logic supply_fail_flag;
        logic underload_flag;
        logic overload_flag;
        logic [`CHANNELS-1:0] outputs;
        logic thermal_warning_flag;
    } stat_t;

    // Pins from outside the clock domain
    typedef struct packed {
        logic supply_a_ov;
        logic supply_b_ov;
        logic driver_uv;
        logic logic_supply_ok;
        logic awake;
        logic [`CHANNELS-1:0] overcurrent;
        logic [`CHANNELS-1:0] underload;
        logic [`SENSORS-1:0] warn;
        logic [`SENSORS-1:0] over_temp;
        logic chip_select_n;
        logic sclk;
        logic sdi;
    } pins_t;

    // Serial frame states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_FRAME = 2'h2
    } frame_state_t;

endpackage

// [test/spi_host_model.sv]
/*
 * Serial host controller model that frames commands to the block.
 * Assumes a free-running core clock; all pins change on its fall.
 */
module spi_host_model (
    input wire logic clk_in,
    output logic chip_select_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic done_out,
    output logic [15:0] rx_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // =================================================================
    // Idle levels: select pulled high, clock and data pulled low
    initial begin
        chip_select_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
        done_out = 1'b0;
        rx_out = 16'h0000;
    end

    // Serial out counts only while the block drives it
    function automatic logic seen();
        return sdo_oe_in ? sdo_in : 1'bx;
    endfunction

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // =================================================================
    // One frame, LSB first; n other than 16 gives a frame to be refused
    task automatic frame(input logic [15:0] tx, input int n);
        logic [15:0] rx;
        rx = 16'h0000;
        chip_select_n_out = 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i++) begin
            sdi_out = tx[i];
            wait_clk(4);
            sclk_out = 1'b1;
            wait_clk(4);
            rx[i] = seen();
            sclk_out = 1'b0;
        end
        wait_clk(4);
        if (n == 0) begin
            rx[0] = seen();
        end
        chip_select_n_out = 1'b1;
        sdi_out = 1'b0;
        rx_out = rx;
        done_out = 1'b1;
        wait_clk(1);
        done_out = 1'b0;
        wait_clk(12);
    endtask
endmodule // spi_host_model

// [test/half_bridge_fault_control_bench.sv]
/*
 * Self-checking bench of the half-bridge fault control block.
 * Assumes hb_fault_map.svh on the include path and the host model.
 */
`include "hb_fault_map.svh"

module half_bridge_fault_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // =================================================================
    // Signals and expectation queues
    logic clk, clk_en, arst_n, awake, supply_ok, drv_uv, ov_a, ov_b;
    logic cs_n, sclk, sdi, sdo, sdo_oe, done;
    logic [`CHANNELS-1:0] oc, ul, drv, en, prev, got;
    logic [`SENSORS-1:0] warn, hot;
    logic [15:0] rx, tx;
    logic [2:0] fl;
    logic [15:0] exp_rx_q[$];
    logic [`CHANNELS-1:0] exp_pin_q[$];
    event snap_ev;
    int seed, errors, compares, idx;

    half_bridge_fault_control dut (
        .clk_in(clk),
        .arst_n_in(arst_n),
        .clk_en_in(clk_en),
        .awake_in(awake),
        .logic_supply_ok_in(supply_ok),
        .driver_supply_uv_in(drv_uv),
        .driver_supply_a_ov_in(ov_a),
        .driver_supply_b_ov_in(ov_b),
        .overcurrent_in(oc),
        .underload_in(ul),
        .thermal_warn_in(warn),
        .over_temp_in(hot),
        .chip_select_n_in(cs_n),
        .sclk_in(sclk),
        .sdi_in(sdi),
        .sdo_out(sdo),
        .sdo_oe_out(sdo_oe),
        .output_driver_n_out(drv)
    );

    spi_host_model host (
        .clk_in(clk),
        .chip_select_n_out(cs_n),
        .sclk_out(sclk),
        .sdi_out(sdi),
        .sdo_in(sdo),
        .sdo_oe_in(sdo_oe),
        .done_out(done),
        .rx_out(rx)
    );

    // =================================================================
    // Compare, expect and closing tasks
    task automatic check_frame(input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("FAIL status frame expected %h seen %h", e, s);
        end
    endtask

    task automatic check_pins(input logic [11:0] e, input logic [11:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("FAIL driver pins expected %h seen %h", e, s);
        end
    endtask

    task automatic expect_pins(input logic [11:0] e);
        exp_pin_q.push_back(e);
        ->snap_ev;
    endtask

    task automatic xfer(input logic [15:0] t, input logic [15:0] e,
                        input int n = 16);
        exp_rx_q.push_back(e);
        host.frame(t, n);
    endtask

    task automatic settle();
        repeat (12) @(negedge clk);
    endtask

    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Result watchers take the oldest note for each result
    always @(posedge clk) begin
        if (done === 1'b1) begin
            check_frame(exp_rx_q.pop_front(), rx);
        end
    end

    always @(snap_ev) begin
        check_pins(exp_pin_q.pop_front(), drv);
    end

    // =================================================================
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(negedge clk);
        errors++;
        conclude();
    end

    // =================================================================
    // Main sequence
    initial begin
        seed = 68555;
        clk_en = 1'b1;
        {awake, supply_ok, drv_uv, ov_a, ov_b} = 5'h18;
        {oc, ul, warn, hot} = '0;
        arst_n = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        settle();
        expect_pins(12'h000);
        prev = 12'h000;
        // Random selections, each frame returns the one before
        for (int n = 0; n < 4; n++) begin
            en = 12'($random(seed));
            xfer({3'b000, en, 1'b0}, {3'b000, prev, 1'b0});
            expect_pins(en);
            prev = en;
        end
        $display("test selection done");
        // Each fault with its policy off and on, then a status reset
        for (int k = 0; k < 3; k++) begin
            for (int pol = 0; pol < 2; pol++) begin
                en = 12'($random(seed)) | 12'h001;
                tx = {3'b000, en, 1'b0};
                tx[13 + k] = (pol == 1);
                xfer(tx, {3'b000, prev, 1'b0});
                oc[0] = (k == 0);
                ul[0] = (k == 1);
                ov_a = (k == 2) && (pol == 0);
                ov_b = (k == 2) && (pol == 1);
                repeat ((k == 1) ? `UL_DELAY_CYC + 20 : 12) @(negedge clk);
                got = (pol == 0) ? en : (k == 2) ? 12'h000 : en & 12'hFFE;
                expect_pins(got);
                {oc, ul, ov_a, ov_b} = '0;
                settle();
                got = (k == 2) ? en : got;
                expect_pins(got);
                fl = 3'b001 << k;
                xfer(tx | 16'h0001, {fl, got, 1'b0});
                expect_pins(en);
                prev = en;
                $display("test fault %0d policy %0d done", k, pol);
            end
        end
        // Warning latches and shows at select fall; shutdown keeps selection
        idx = $unsigned($random(seed)) % `SENSORS;
        warn[idx] = 1'b1;
        settle();
        xfer(16'h0000, 16'h0001, 0);
        en = 12'($random(seed)) | 12'h001;
        xfer({3'b000, en, 1'b0}, {3'b000, prev, 1'b1});
        expect_pins(en);
        warn = '0;
        hot[5 - idx] = 1'b1;
        settle();
        expect_pins(12'h000);
        prev = en ^ 12'hFFF;
        xfer({3'b000, prev, 1'b0}, {3'b000, 12'h000, 1'b1});
        expect_pins(12'h000);
        hot = '0;
        settle();
        expect_pins(prev);
        xfer({3'b000, prev, 1'b1}, {3'b000, prev, 1'b1});
        xfer(16'h0000, 16'h0000, 0);
        $display("test thermal done");
        // Short frame is dropped
        xfer({3'b000, ~prev, 1'b0}, {3'b000, prev, 1'b0}, 15);
        expect_pins(prev);
        // Supply and sleep handling; a low clock enable freezes all state
        clk_en = 1'b0;
        drv_uv = 1'b1;
        settle();
        expect_pins(prev);
        clk_en = 1'b1;
        settle();
        expect_pins(12'h000);
        drv_uv = 1'b0;
        settle();
        expect_pins(prev);
        supply_ok = 1'b0;
        settle();
        expect_pins(12'h000);
        xfer({3'b000, prev, 1'b0}, 16'h0000);
        supply_ok = 1'b1;
        settle();
        expect_pins(12'h000);
        xfer({3'b000, prev, 1'b0}, 16'h0000);
        expect_pins(prev);
        awake = 1'b0;
        settle();
        expect_pins(12'h000);
        awake = 1'b1;
        settle();
        xfer(16'h0000, 16'h0000);
        expect_pins(12'h000);
        $display("test supply done");
        @(negedge clk);
        if (exp_rx_q.size() + exp_pin_q.size() != 0) begin
            errors++;
        end
        conclude();
    end
endmodule // half_bridge_fault_control_bench
